// ### bench/dcd_link_asserts.sv
// Purpose: checks on the link between scanner and directory
// Assumes: sits beside the scanner link only
// Notes:   helper regs keep the last entry read by the scanner
`timescale 1ns/1ps
`include "dcd_cfg.svh"
module dcd_link_asserts
    import dcd_pkg::*;
#(
    parameter int N_ENTRIES = 4
) (
    input wire logic      i_mclk,
    input wire logic      i_reset_n,
    input wire logic      i_ce,
    input wire logic      req,
    input wire logic      we,
    input wire dcd_addr_t addr,
    input wire dcd_word_t wdata,
    input wire logic      ack,
    input wire dcd_word_t rdata
);
    // ------------------------------------------------------------
    // helper state and properties
    // ------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);
    dcd_addr_t  last_addr;
    logic [4:0] last_pid;
    logic       last_vld;
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            last_addr <= 12'h000;
            last_pid  <= 5'h00;
            last_vld  <= 1'b0;
        end else if (ack && !we) begin
            last_addr <= addr;
            last_pid  <= rdata[8:4];
            last_vld  <= rdata[0] & rdata[2];
        end
    end
    ack_follows_a: assert property (
        req && !ack && i_ce |=> ack) else $error("ack missing");
    ack_pulse_a: assert property (
        ack |=> !ack) else $error("ack longer than one cycle");
    gap_zero_a: assert property (
        req && !we && !ack && i_ce && addr[11:2] >= N_ENTRIES
        && addr < `DCD_RSVD_BASE |=> rdata == `DCD_ZERO)
        else $error("gap word not zero");
    term_stop_a: assert property (
        ack && !we && rdata[1:0] == 2'b00 |=> !req [*2])
        else $error("scan went past terminator");
    skip_on_a: assert property (
        ack && !we && rdata[1:0] == 2'b10 |-> ##[2:6] (req && !we))
        else $error("scan stopped at skipped entry");
    scan_consec_a: assert property (
        $rose(req) && !we && addr != 12'h000
        |-> addr == last_addr + 12'h004)
        else $error("entry read out of order");
    write_region_a: assert property (
        req && we |-> addr >= `DCD_DBGPCR_BASE && addr < `DCD_DBGPSR_BASE)
        else $error("write outside power request regs");
    power_write_a: assert property (
        req && we && wdata[0]
        |-> last_vld && addr == `DCD_DBGPCR_BASE + {last_pid, 2'b00})
        else $error("power request for wrong domain");
endmodule

// ### bench/tb.sv
// Purpose: bench for scanner and directory joined by one link
// Assumes: four entries, domains 1 and 0 listed, entry 1 skipped
// Notes:   a second directory is driven by the bench as host
`timescale 1ns/1ps
`include "dcd_cfg.svh"
module tb;
    import dcd_pkg::*;
    localparam int N = 4;
    localparam logic [N*32-1:0] ENT =
        128'h0000_4007_0000_3003_0000_2002_0000_1017;
    localparam dcd_word_t ARCH = 32'h5a5a_0af7; // arbitrary value
    logic        mclk, reset_n, ce, start, rel, rst_ack, busy, done;
    logic [7:0]  auth;
    logic [9:0]  count;
    logic        drst2, srst2;
    logic [31:0] pwr_on, powered, dreq, dreq2, sreq2;
    dcd_word_t   q;
    int          n_errors, comparisons, cycles;
    dcd_link_if  lk ();
    dcd_link_if  lk2 ();
    // ------------------------------------------------------------
    // instances
    // ------------------------------------------------------------
    dcd_directory #(.N_ENTRIES(N), .ENTRIES(ENT)) i_dcd_directory (
        .i_mclk(mclk), .i_reset_n(reset_n), .i_ce(ce), .link(lk),
        .o_dbg_pwr_req(dreq), .i_dbg_pwr_on(pwr_on),
        .o_sys_pwr_req(), .i_sys_pwr_on(pwr_on),
        .o_dbg_rst_req(), .i_dbg_rst_ack(rst_ack),
        .o_sys_rst_req(), .i_sys_rst_ack(rst_ack), .i_auth_state(auth));
    dcd_directory #(.N_ENTRIES(N), .ENTRIES(ENT), .ARCH_ID(ARCH))
    i_dcd_directory2 (
        .i_mclk(mclk), .i_reset_n(reset_n), .i_ce(ce), .link(lk2),
        .o_dbg_pwr_req(dreq2), .i_dbg_pwr_on(pwr_on),
        .o_sys_pwr_req(sreq2), .i_sys_pwr_on(pwr_on),
        .o_dbg_rst_req(drst2), .i_dbg_rst_ack(rst_ack),
        .o_sys_rst_req(srst2), .i_sys_rst_ack(rst_ack), .i_auth_state(auth));
    dcd_scanner i_dcd_scanner (
        .i_mclk(mclk), .i_reset_n(reset_n), .i_ce(ce), .link(lk),
        .i_start(start), .i_release(rel), .o_busy(busy), .o_done(done),
        .o_count(count), .o_powered(powered));
    dcd_link_asserts #(.N_ENTRIES(N)) i_dcd_link_asserts (
        .i_mclk(mclk), .i_reset_n(reset_n), .i_ce(ce), .req(lk.req),
        .we(lk.we), .addr(lk.addr), .wdata(lk.wdata), .ack(lk.ack),
        .rdata(lk.rdata));
    // ------------------------------------------------------------
    // tasks and sequence
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            final_report();
        end
    end
    task automatic final_report();
        if (n_errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // request held until ack is seen, dropped the cycle after the ack cycle
    task automatic bus(input logic w, input dcd_addr_t a,
                       input dcd_word_t d, output dcd_word_t r);
        int k;
        @(negedge mclk);
        lk2.req = 1'b1;
        lk2.we = w;
        lk2.addr = a;
        lk2.wdata = d;
        k = 0;
        do begin
            @(negedge mclk);
            k++;
        end while (lk2.ack !== 1'b1 && k < 20);
        r = lk2.rdata;
        if (lk2.ack !== 1'b1) n_errors++;
        // hold past the edge that samples ack high
        @(negedge mclk);
        lk2.req = 1'b0;
    endtask
    task automatic rd_chk(input dcd_addr_t a, input dcd_word_t e);
        dcd_word_t r;
        bus(1'b0, a, 32'h0, r);
        chk(r, e);
    endtask
    task automatic wait_done();
        int k;
        k = 0;
        while (done !== 1'b1 && k < 300) begin
            @(negedge mclk);
            k++;
        end
    endtask
    task automatic scan_test();
        @(negedge mclk);
        start = 1'b1;
        @(negedge mclk);
        start = 1'b0;
        wait_done();
        chk(32'(done), 32'h1);
        chk(32'(count), 32'h3);
        chk(powered, 32'h3);
        chk(dreq, 32'h3);
        chk(32'(busy), 32'h0);
        @(negedge mclk);
        chk(32'(done), 32'h0);
        repeat (4) @(negedge mclk);
    endtask
    task automatic release_test();
        @(negedge mclk);
        rel = 1'b1;
        @(negedge mclk);
        rel = 1'b0;
        wait_done();
        chk(powered, 32'h0);
        chk(dreq, 32'h0);
    endtask
    task automatic reg_test();
        rd_chk(12'h000, ENT[31:0]);
        rd_chk(12'h00c, ENT[127:96]);
        rd_chk(12'h010, 32'h0);
        rd_chk(12'h7fc, 32'h0);
        rd_chk(12'h800, 32'h0);
        bus(1'b1, 12'h004, 32'hffff_ffff, q);
        rd_chk(12'h004, ENT[63:32]);
        rd_chk(12'hff4, 32'h0000_0090);
        rd_chk(12'hfb0, ARCH);
    endtask
    task automatic pcr_test();
        pwr_on = 32'h1;
        rd_chk(12'ha04, 32'h2);
        bus(1'b1, 12'ha00, 32'h1, q);
        rd_chk(12'ha00, 32'h3);
        chk(dreq2, 32'h1);
        bus(1'b1, 12'ha08, 32'h1, q);
        rd_chk(12'ha08, 32'h0);
        chk(dreq2, 32'h1);
        rd_chk(12'ha80, 32'h1);
    endtask
    // a request held while the enable is low must not be answered
    task automatic ce_test();
        @(negedge mclk);
        ce = 1'b0;
        lk2.req = 1'b1;
        lk2.we = 1'b1;
        lk2.addr = 12'ha04;
        lk2.wdata = 32'h1;
        repeat (3) @(negedge mclk);
        chk(32'(lk2.ack), 32'h0);
        chk(dreq2, 32'h1);
        lk2.req = 1'b0;
        ce = 1'b1;
        bus(1'b1, 12'ha04, 32'h1, q);
        chk(dreq2, 32'h3);
    endtask
    task automatic rst_test();
        bus(1'b1, 12'hc10, 32'h1, q);
        bus(1'b1, 12'hc18, 32'h1, q);
        bus(1'b1, 12'hb00, 32'h1, q);
        chk(32'(drst2), 32'h1);
        chk(32'(srst2), 32'h1);
        chk(sreq2, 32'h1);
        rd_chk(12'hc14, 32'h0);
        rd_chk(12'hc00, 32'h3);
    endtask
    initial begin
        n_errors = 0;
        comparisons = 0;
        cycles = 0;
        reset_n = 1'b0;
        ce = 1'b1;
        start = 1'b0;
        rel = 1'b0;
        rst_ack = 1'b0;
        auth = 8'h00;
        pwr_on = 32'h0;
        lk2.req = 1'b0;
        lk2.we = 1'b0;
        lk2.addr = 12'h000;
        lk2.wdata = 32'h0;
        repeat (8) @(negedge mclk);
        reset_n = 1'b1;
        scan_test();
        release_test();
        reg_test();
        pcr_test();
        ce_test();
        rst_test();
        final_report();
    end
endmodule

// ### pkg/dcd_cfg.svh
// Purpose: address map, field positions and fixed values of the directory
// Assumes: 4KB block, word-aligned 32-bit accesses
// Notes:   included by both ends and the package
`ifndef DCD_CFG_SVH
`define DCD_CFG_SVH
// ----------------------------------------------------------------------
// address map (byte offsets)
// ----------------------------------------------------------------------
`define DCD_ADDR_W        12
`define DCD_ENTRY_BASE    12'h000
`define DCD_ENTRY_LAST    12'h7fc
`define DCD_ENTRY_MAX     512
`define DCD_RSVD_BASE     12'h800
`define DCD_DBGPCR_BASE   12'ha00
`define DCD_DBGPSR_BASE   12'ha80
`define DCD_SYSPCR_BASE   12'hb00
`define DCD_SYSPSR_BASE   12'hb80
`define DCD_PWR_ID_OFF    12'hc00
`define DCD_DRST_REQ_OFF  12'hc10
`define DCD_DRST_ACK_OFF  12'hc14
`define DCD_SRST_REQ_OFF  12'hc18
`define DCD_SRST_ACK_OFF  12'hc1c
`define DCD_INTEGRATION_MODE_CONTROL_OFF    12'hf00
`define DCD_TAGSET_OFF    12'hfa0
`define DCD_TAGCLR_OFF    12'hfa4
`define DCD_AFF0_OFF      12'hfa8
`define DCD_ARCH_OFF      12'hfb0
`define DCD_LOCK_OFF      12'hfb4
`define DCD_AUTH_OFF      12'hfb8
`define DCD_DEVICE_CONFIG_TWO_OFF    12'hfc0
`define DCD_DEVICE_CONFIG_ONE_OFF    12'hfc4
`define DCD_DEVID0_OFF    12'hfc8
`define DCD_DEVICE_TYPE_CODE_OFF   12'hfcc
`define DCD_PIDR4_OFF     12'hfd0
`define DCD_PIDR0_OFF     12'hfe0
`define DCD_CIDR0_OFF     12'hff0
`define DCD_CIDR1_OFF     12'hff4
`define DCD_CIDR2_OFF     12'hff8
`define DCD_CIDR3_OFF     12'hffc
// ----------------------------------------------------------------------
// fields
// ----------------------------------------------------------------------
`define DCD_ENT_PRESENT   0
`define DCD_ENT_FORMAT    1
`define DCD_ENT_PIDVALID  2
`define DCD_ENT_PID_LO    4
`define DCD_ENT_PID_HI    8
`define DCD_PCR_REQ       0
`define DCD_PCR_IMPL      1
`define DCD_PSR_ON        0
`define DCD_RST_BIT       0
`define DCD_TAG_W         4
`define DCD_DOMAINS       32
`define DCD_CIDR0_VAL     32'h0000_0000
`define DCD_CIDR1_VAL     32'h0000_0090
`define DCD_CIDR2_VAL     32'h0000_0005
`define DCD_CIDR3_VAL     32'h0000_0081
`define DCD_ZERO          32'h0000_0000
`endif

// ### pkg/dcd_link_if.sv
// Purpose: access port carrying word reads and writes into the directory
// Assumes: one clock, request held until answered
// Notes:   ack is a one-cycle pulse with read data
`timescale 1ns/1ps
interface dcd_link_if;
    import dcd_pkg::*;
    logic      req;
    logic      we;
    dcd_addr_t addr;
    dcd_word_t wdata;
    logic      ack;
    dcd_word_t rdata;
    modport dev (input req, input we, input addr, input wdata,
                 output ack, output rdata);
    modport host (output req, output we, output addr, output wdata,
                  input ack, input rdata);
endinterface

// ### pkg/dcd_pkg.sv
// Purpose: shared types of the directory ends
// Assumes: dcd_cfg.svh holds all numbers
// Notes:   state codes are one-hot
`include "dcd_cfg.svh"
package dcd_pkg;
    typedef logic [31:0]              dcd_word_t;
    typedef logic [`DCD_ADDR_W-1:0]   dcd_addr_t;
    typedef enum logic [5:0] {
        DCD_S_IDLE  = 6'h01,
        DCD_S_RD    = 6'h02,
        DCD_S_RWAIT = 6'h04,
        DCD_S_WR    = 6'h08,
        DCD_S_WWAIT = 6'h10,
        DCD_S_REL   = 6'h20
    } dcd_state_t;
endpackage

// ### rtl/dcd_directory.sv
// Purpose: debug component directory with power and reset request regs
// Assumes: entries come from static tie-off parameters
// Notes:   one access answered per request, one cycle after it is seen
`timescale 1ns/1ps
`include "dcd_cfg.svh"
module dcd_directory
    import dcd_pkg::*;
#(
    parameter int                         N_ENTRIES  = 4,
    parameter logic [N_ENTRIES*32-1:0]    ENTRIES    = '0,
    parameter logic [`DCD_DOMAINS-1:0]    DBG_IMPL   = 32'h0000_0003,
    parameter logic [`DCD_DOMAINS-1:0]    SYS_IMPL   = 32'h0000_0001,
    // identity values below are arbitrary
    parameter dcd_word_t                  ARCH_ID    = 32'h1234_0af7,
    parameter dcd_word_t                  PART_ID    = 32'h0000_0055,
    parameter dcd_word_t                  DEVICE_TYPE_CODE_ID = 32'h0000_0000
) (
    // clock and reset
    input  wire logic                    i_mclk,
    input  wire logic                    i_reset_n,
    input  wire logic                    i_ce,
    // access port
    dcd_link_if.dev                      link,
    // debug power domains
    output logic [`DCD_DOMAINS-1:0]      o_dbg_pwr_req,
    input  wire logic [`DCD_DOMAINS-1:0] i_dbg_pwr_on,
    // system power domains
    output logic [`DCD_DOMAINS-1:0]      o_sys_pwr_req,
    input  wire logic [`DCD_DOMAINS-1:0] i_sys_pwr_on,
    // reset requests
    output logic                         o_dbg_rst_req,
    input  wire logic                    i_dbg_rst_ack,
    output logic                         o_sys_rst_req,
    input  wire logic                    i_sys_rst_ack,
    // authentication
    input  wire logic [7:0]              i_auth_state
);
    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    localparam int IDX_W = 9;
    localparam dcd_addr_t DPCR_BASE = `DCD_DBGPCR_BASE;
    localparam dcd_addr_t DPSR_BASE = `DCD_DBGPSR_BASE;
    localparam dcd_addr_t SPCR_BASE = `DCD_SYSPCR_BASE;
    localparam dcd_addr_t SPSR_BASE = `DCD_SYSPSR_BASE;

    logic [IDX_W-1:0]     idx;
    logic [4:0]           dom;
    logic                 in_entries;
    logic                 wr;
    logic [`DCD_TAG_W-1:0] claim;
    logic                 it_mode;
    dcd_word_t            next_rdata;
    dcd_word_t            ent;

    assign idx        = link.addr[IDX_W+1:2];
    assign dom        = link.addr[6:2];
    assign in_entries = link.addr < `DCD_RSVD_BASE;
    // a request is seen once: ack drops it for the cycle it is answered
    assign wr         = i_ce & link.req & link.we & ~link.ack;

    // entries beyond the populated count read zero, which also forms the
    // terminator; a full 512-entry table simply has no gap
    always_comb begin
        ent = `DCD_ZERO;
        if (int'(idx) < N_ENTRIES) begin
            ent = ENTRIES[int'(idx)*32 +: 32];
        end
        if (int'(idx) >= N_ENTRIES) begin
            ent = `DCD_ZERO;
        end
        // 0x7fc is index 511, the last word a 9-bit index reaches
    end

    // ------------------------------------------------------------------
    // power request registers
    // ------------------------------------------------------------------
    // power indices here only name domains behind this directory
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_dbg_pwr_req <= '0;
        end else if (wr && link.addr[11:7] == DPCR_BASE[11:7]) begin
            // an unimplemented domain keeps its request at zero
            o_dbg_pwr_req[dom] <= link.wdata[`DCD_PCR_REQ]
                                  & DBG_IMPL[dom];
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_sys_pwr_req <= '0;
        end else if (wr && link.addr[11:7] == SPCR_BASE[11:7]) begin
            o_sys_pwr_req[dom] <= link.wdata[`DCD_PCR_REQ]
                                  & SYS_IMPL[dom];
        end
    end

    // ------------------------------------------------------------------
    // reset requests
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_dbg_rst_req <= 1'b0;
            o_sys_rst_req <= 1'b0;
        end else if (wr) begin
            if (link.addr == `DCD_DRST_REQ_OFF) begin
                o_dbg_rst_req <= link.wdata[`DCD_RST_BIT];
            end
            if (link.addr == `DCD_SRST_REQ_OFF) begin
                o_sys_rst_req <= link.wdata[`DCD_RST_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // management registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            claim   <= '0;
            it_mode <= 1'b0;
        end else if (wr) begin
            if (link.addr == `DCD_TAGSET_OFF) begin
                claim <= claim | link.wdata[`DCD_TAG_W-1:0];
            end
            if (link.addr == `DCD_TAGCLR_OFF) begin
                claim <= claim & ~link.wdata[`DCD_TAG_W-1:0];
            end
            if (link.addr == `DCD_INTEGRATION_MODE_CONTROL_OFF) begin
                it_mode <= link.wdata[0];
            end
        end
    end

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    always_comb begin
        next_rdata = `DCD_ZERO;
        if (in_entries) begin
            next_rdata = ent;
        end else if (link.addr[11:7] == DPCR_BASE[11:7]) begin
            next_rdata[`DCD_PCR_REQ]  = o_dbg_pwr_req[dom];
            next_rdata[`DCD_PCR_IMPL] = DBG_IMPL[dom];
        end else if (link.addr[11:7] == DPSR_BASE[11:7]) begin
            next_rdata[`DCD_PSR_ON] = i_dbg_pwr_on[dom];
        end else if (link.addr[11:7] == SPCR_BASE[11:7]) begin
            next_rdata[`DCD_PCR_REQ]  = o_sys_pwr_req[dom];
            next_rdata[`DCD_PCR_IMPL] = SYS_IMPL[dom];
        end else if (link.addr[11:7] == SPSR_BASE[11:7]) begin
            next_rdata[`DCD_PSR_ON] = i_sys_pwr_on[dom];
        end else begin
            unique case (link.addr)
                `DCD_PWR_ID_OFF:   next_rdata = {30'h0, |SYS_IMPL, |DBG_IMPL};
                `DCD_DRST_REQ_OFF: next_rdata[0] = o_dbg_rst_req;
                `DCD_DRST_ACK_OFF: next_rdata[0] = i_dbg_rst_ack;
                `DCD_SRST_REQ_OFF: next_rdata[0] = o_sys_rst_req;
                `DCD_SRST_ACK_OFF: next_rdata[0] = i_sys_rst_ack;
                `DCD_INTEGRATION_MODE_CONTROL_OFF:   next_rdata[0] = it_mode;
                `DCD_TAGSET_OFF:   next_rdata = 32'h0000_000f;
                `DCD_TAGCLR_OFF:   next_rdata = {28'h0, claim};
                `DCD_ARCH_OFF:     next_rdata = ARCH_ID;
                `DCD_AUTH_OFF:     next_rdata = {24'h0, i_auth_state};
                `DCD_DEVICE_TYPE_CODE_OFF:  next_rdata = DEVICE_TYPE_CODE_ID;
                `DCD_PIDR0_OFF:    next_rdata = PART_ID;
                `DCD_CIDR0_OFF:    next_rdata = `DCD_CIDR0_VAL;
                `DCD_CIDR1_OFF:    next_rdata = `DCD_CIDR1_VAL;
                `DCD_CIDR2_OFF:    next_rdata = `DCD_CIDR2_VAL;
                `DCD_CIDR3_OFF:    next_rdata = `DCD_CIDR3_VAL;
                default:           next_rdata = `DCD_ZERO;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // answer
    // ------------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            link.ack   <= 1'b0;
            link.rdata <= '0;
        end else if (i_ce) begin
            link.ack <= link.req & ~link.ack;
            if (link.req && !link.ack && !link.we) begin
                link.rdata <= next_rdata;
            end
        end
    end
endmodule

// ### rtl/dcd_scanner.sv
// Purpose: debugger end: walks the directory and powers listed domains
// Assumes: one directory at base zero of the link
// Notes:   subordinate directories are left to the user to walk
`timescale 1ns/1ps
`include "dcd_cfg.svh"
module dcd_scanner
    import dcd_pkg::*;
(
    // clock and reset
    input  wire logic                 i_mclk,
    input  wire logic                 i_reset_n,
    input  wire logic                 i_ce,
    // access port
    dcd_link_if.host                  link,
    // user control
    input  wire logic                 i_start,
    input  wire logic                 i_release,
    output logic                      o_busy,
    output logic                      o_done,
    output logic [9:0]                o_count,
    output logic [`DCD_DOMAINS-1:0]   o_powered
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    dcd_state_t  st;
    dcd_addr_t   addr;
    logic [4:0]  rel;
    logic [4:0]  pid;
    dcd_word_t   e;
    logic        last;

    assign e    = link.rdata;
    assign pid  = e[`DCD_ENT_PID_HI:`DCD_ENT_PID_LO];
    assign last = addr == `DCD_ENTRY_LAST;

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st         <= DCD_S_IDLE;
            addr       <= '0;
            rel        <= '0;
            o_busy     <= 1'b0;
            o_done     <= 1'b0;
            o_count    <= '0;
            o_powered  <= '0;
            link.req   <= 1'b0;
            link.we    <= 1'b0;
            link.addr  <= '0;
            link.wdata <= '0;
        end else if (i_ce) begin
            o_done <= 1'b0;
            unique case (st)
                DCD_S_IDLE: begin
                    if (i_start) begin
                        addr    <= `DCD_ENTRY_BASE;
                        o_count <= '0;
                        o_busy  <= 1'b1;
                        st      <= DCD_S_RD;
                    end else if (i_release) begin
                        rel    <= '0;
                        o_busy <= 1'b1;
                        st     <= DCD_S_REL;
                    end
                end
                DCD_S_RD: begin
                    link.req  <= 1'b1;
                    link.we   <= 1'b0;
                    link.addr <= addr;
                    st        <= DCD_S_RWAIT;
                end
                DCD_S_RWAIT: begin
                    if (link.ack) begin
                        link.req <= 1'b0;
                        if (e[1:0] == 2'b00 && !last) begin
                            o_busy <= 1'b0;
                            o_done <= 1'b1;
                            st     <= DCD_S_IDLE;
                        end else if (e[`DCD_ENT_PRESENT]
                                     && e[`DCD_ENT_PIDVALID]
                                     && !o_powered[pid]) begin
                            // request goes to this same directory
                            o_count    <= o_count + 10'h001;
                            link.addr  <= `DCD_DBGPCR_BASE
                                          | {5'h00, pid, 2'b00};
                            link.wdata <= 32'h0000_0001;
                            o_powered[pid] <= 1'b1;
                            st         <= DCD_S_WR;
                        end else begin
                            // absent-but-skipped entries are not counted
                            if (e[`DCD_ENT_PRESENT]) begin
                                o_count <= o_count + 10'h001;
                            end
                            // absent, no valid index, or domain already powered
                            if (last) begin
                                o_busy <= 1'b0;
                                o_done <= 1'b1;
                                st     <= DCD_S_IDLE;
                            end else begin
                                addr <= addr + 12'h004;
                                st   <= DCD_S_RD;
                            end
                        end
                    end
                end
                DCD_S_WR: begin
                    link.req <= 1'b1;
                    link.we  <= 1'b1;
                    st       <= DCD_S_WWAIT;
                end
                DCD_S_WWAIT: begin
                    if (link.ack) begin
                        link.req <= 1'b0;
                        link.we  <= 1'b0;
                        if (o_busy && link.wdata == `DCD_ZERO) begin
                            rel <= rel + 5'h01;
                            if (rel == 5'h1f) begin
                                o_busy <= 1'b0;
                                o_done <= 1'b1;
                                st     <= DCD_S_IDLE;
                            end else begin
                                st <= DCD_S_REL;
                            end
                        end else if (last) begin
                            o_busy <= 1'b0;
                            o_done <= 1'b1;
                            st     <= DCD_S_IDLE;
                        end else begin
                            addr <= addr + 12'h004;
                            st   <= DCD_S_RD;
                        end
                    end
                end
                DCD_S_REL: begin
                    if (o_powered[rel]) begin
                        o_powered[rel] <= 1'b0;
                        link.addr  <= `DCD_DBGPCR_BASE | {5'h00, rel, 2'b00};
                        link.wdata <= `DCD_ZERO;
                        st         <= DCD_S_WR;
                    end else if (rel == 5'h1f) begin
                        o_busy <= 1'b0;
                        o_done <= 1'b1;
                        st     <= DCD_S_IDLE;
                    end else begin
                        rel <= rel + 5'h01;
                    end
                end
                default: st <= DCD_S_IDLE;
            endcase
        end
    end
endmodule
